// file: rtl/eirl_pkg.sv
// Package for the external interrupt request latch.
// Assumes a single 200 MHz clock; all inputs synchronous to it.
package eirl_pkg;
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned MIN_REQUEST_LOW_TIME_NS = 250;
	localparam int unsigned LOW_CYCLES = (MIN_REQUEST_LOW_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned LOW_CNT_W = 6;
	localparam int unsigned PORT_A_W = 6;
	localparam int unsigned SPACING_EXTRA_CYCLES = 21;
	localparam logic [LOW_CNT_W-1:0] LOW_CYCLES_C = LOW_CNT_W'(LOW_CYCLES);

	typedef enum logic [1:0] {
		EIRL_IDLE = 2'b00,
		EIRL_ARMED = 2'b01,
		EIRL_LATCHED = 2'b10
	} eirl_state_t;

	typedef struct packed {
		logic irq_n;
		logic [PORT_A_W-1:0] port_a_lines;
		logic [PORT_A_W-1:0] port_a_enable;
	} eirl_req_t;

	typedef struct packed {
		logic instr_done;
		logic mask_flag;
	} eirl_cpu_t;
endpackage

// file: rtl/eirl_latch.sv
// External interrupt request latch: filters the wire-ORed request line and
// latches a request, offered to the CPU at each instruction boundary.
// Assumes request pins already synchronised, CPU gives instruction-done pulse.
// Operation
// - Build option: edge only, or edge plus level
// - Level option requests on edge or sustained low
// - Latch sets after minimum low time held
// - Latch tested only at instruction completion
// - Start sequence when latched and mask clear
// - Masked request stays latched, never lost
module eirl_latch #(
	parameter bit LEVEL_SENSE = 1'b1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Request pins and CPU handshake
	input wire eirl_pkg::eirl_req_t req,
	input wire eirl_pkg::eirl_cpu_t cpu,
	// Status and sequence start
	output logic request_pending,
	output logic start_sequence
);
	import eirl_pkg::*;

	logic line_low;
	logic [LOW_CNT_W-1:0] low_cnt;
	logic [LOW_CNT_W-1:0] next_low_cnt;
	logic seen_high;
	logic next_seen_high;
	eirl_state_t state;
	eirl_state_t next_state;
	logic next_start;
	logic qualified;

	// Wire-OR of the request pin and enabled port lines, active low
	assign line_low = !req.irq_n || |(~req.port_a_lines & req.port_a_enable);

	always_comb begin
		next_low_cnt = low_cnt;
		next_seen_high = seen_high;
		next_state = state;
		next_start = 1'b0;
		qualified = 1'b0;
		if (!line_low) begin
			next_low_cnt = '0;
			next_seen_high = 1'b1;
		end else if (low_cnt != LOW_CYCLES_C) begin
			next_low_cnt = low_cnt + LOW_CNT_W'(1);
		end
		// Qualified once low for the minimum time
		if (line_low && low_cnt == LOW_CYCLES_C - LOW_CNT_W'(1)) begin
			qualified = seen_high || LEVEL_SENSE;
		end
		if (line_low && low_cnt == LOW_CYCLES_C && LEVEL_SENSE && state == EIRL_IDLE) begin
			qualified = 1'b1;
		end
		case (state)
			EIRL_IDLE: begin
				if (qualified) begin
					next_state = EIRL_LATCHED;
					next_seen_high = 1'b0;
				end
			end
			EIRL_LATCHED: begin
				if (cpu.instr_done && !cpu.mask_flag) begin
					next_start = 1'b1;
					next_state = EIRL_ARMED;
				end
			end
			EIRL_ARMED: begin
				next_state = EIRL_IDLE;
			end
			default: begin
				next_state = EIRL_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt <= '0;
			seen_high <= 1'b0;
			state <= EIRL_IDLE;
			start_sequence <= 1'b0;
			request_pending <= 1'b0;
		end else begin
			low_cnt <= next_low_cnt;
			seen_high <= next_seen_high;
			state <= next_state;
			start_sequence <= next_start;
			request_pending <= (next_state == EIRL_LATCHED);
		end
	end

	property p_start_needs_unmasked;
		@(posedge ref_clk) disable iff (!rst_n)
		start_sequence |-> $past(cpu.instr_done) && !$past(cpu.mask_flag) && $past(state) == EIRL_LATCHED;
	endproperty
	a_start_needs_unmasked: assert property (p_start_needs_unmasked) else $error("start without latch or unmasked boundary");

	property p_boundary_only;
		@(posedge ref_clk) disable iff (!rst_n)
		!$past(cpu.instr_done) |-> !start_sequence;
	endproperty
	a_boundary_only: assert property (p_boundary_only) else $error("start outside instruction boundary");

	property p_masked_held;
		@(posedge ref_clk) disable iff (!rst_n)
		state == EIRL_LATCHED && cpu.mask_flag |=> state == EIRL_LATCHED;
	endproperty
	a_masked_held: assert property (p_masked_held) else $error("masked request lost");

	property p_clear_on_entry;
		@(posedge ref_clk) disable iff (!rst_n)
		start_sequence |-> !request_pending ##1 !request_pending;
	endproperty
	a_clear_on_entry: assert property (p_clear_on_entry) else $error("latch not cleared on entry");

	property p_min_low;
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(request_pending) && $past(state) == EIRL_IDLE |-> $past(low_cnt) == LOW_CYCLES_C - LOW_CNT_W'(1)
			|| $past(low_cnt) == LOW_CYCLES_C;
	endproperty
	a_min_low: assert property (p_min_low) else $error("latched before minimum low time");

	property p_edge_only;
		@(posedge ref_clk) disable iff (!rst_n)
		!LEVEL_SENSE && state == EIRL_IDLE && !seen_high |=> state != EIRL_LATCHED;
	endproperty
	a_edge_only: assert property (p_edge_only) else $error("level latched in edge-only build");

	property p_level_latches;
		@(posedge ref_clk) disable iff (!rst_n)
		LEVEL_SENSE && state == EIRL_IDLE && line_low && low_cnt == LOW_CYCLES_C |=> state == EIRL_LATCHED;
	endproperty
	a_level_latches: assert property (p_level_latches) else $error("sustained low not latched");

	property p_pending_matches_state;
		@(posedge ref_clk) disable iff (!rst_n)
		request_pending == (state == EIRL_LATCHED);
	endproperty
	a_pending_matches_state: assert property (p_pending_matches_state) else $error("pending flag off latch");

	property p_start_one_cycle;
		@(posedge ref_clk) disable iff (!rst_n)
		start_sequence |=> !start_sequence;
	endproperty
	a_start_one_cycle: assert property (p_start_one_cycle) else $error("start longer than one cycle");

	property p_start_clears;
		@(posedge ref_clk) disable iff (!rst_n)
		start_sequence |-> state == EIRL_ARMED;
	endproperty
	a_start_clears: assert property (p_start_clears) else $error("latch held after start");

	property p_armed_to_idle;
		@(posedge ref_clk) disable iff (!rst_n)
		state == EIRL_ARMED |=> state == EIRL_IDLE;
	endproperty
	a_armed_to_idle: assert property (p_armed_to_idle) else $error("armed state not left");

	property p_unmasked_starts;
		@(posedge ref_clk) disable iff (!rst_n)
		state == EIRL_LATCHED && cpu.instr_done && !cpu.mask_flag |=> start_sequence;
	endproperty
	a_unmasked_starts: assert property (p_unmasked_starts) else $error("unmasked boundary did not start");

	property p_no_boundary_holds;
		@(posedge ref_clk) disable iff (!rst_n)
		state == EIRL_LATCHED && !cpu.instr_done |=> state == EIRL_LATCHED && !start_sequence;
	endproperty
	a_no_boundary_holds: assert property (p_no_boundary_holds) else $error("latch acted mid instruction");

	property p_high_resets_count;
		@(posedge ref_clk) disable iff (!rst_n)
		!line_low |=> low_cnt == '0;
	endproperty
	a_high_resets_count: assert property (p_high_resets_count) else $error("low count not cleared");

	property p_count_saturates;
		@(posedge ref_clk) disable iff (!rst_n)
		line_low && low_cnt == LOW_CYCLES_C |=> low_cnt == LOW_CYCLES_C;
	endproperty
	a_count_saturates: assert property (p_count_saturates) else $error("low count left its ceiling");

	property p_count_steps;
		@(posedge ref_clk) disable iff (!rst_n)
		line_low && low_cnt != LOW_CYCLES_C |=> low_cnt == $past(low_cnt) + LOW_CNT_W'(1);
	endproperty
	a_count_steps: assert property (p_count_steps) else $error("low count skipped");

	property p_short_low_ignored;
		@(posedge ref_clk) disable iff (!rst_n)
		state == EIRL_IDLE && line_low && low_cnt < LOW_CYCLES_C - LOW_CNT_W'(1) |=> state == EIRL_IDLE;
	endproperty
	a_short_low_ignored: assert property (p_short_low_ignored) else $error("short low latched");

	property p_latch_needs_low;
		@(posedge ref_clk) disable iff (!rst_n)
		state == EIRL_IDLE && !line_low |=> state == EIRL_IDLE;
	endproperty
	a_latch_needs_low: assert property (p_latch_needs_low) else $error("latched with line high");

	property p_edge_latch;
		@(posedge ref_clk) disable iff (!rst_n)
		state == EIRL_IDLE && line_low && seen_high && low_cnt == LOW_CYCLES_C - LOW_CNT_W'(1) |=> state == EIRL_LATCHED;
	endproperty
	a_edge_latch: assert property (p_edge_latch) else $error("falling edge not latched");

	property p_seen_high_set;
		@(posedge ref_clk) disable iff (!rst_n)
		!line_low |=> seen_high;
	endproperty
	a_seen_high_set: assert property (p_seen_high_set) else $error("high line not remembered");

	property p_seen_cleared;
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(request_pending) |-> !seen_high;
	endproperty
	a_seen_cleared: assert property (p_seen_cleared) else $error("edge memory kept after latch");

	property p_count_bound;
		@(posedge ref_clk) disable iff (!rst_n)
		low_cnt <= LOW_CYCLES_C;
	endproperty
	a_count_bound: assert property (p_count_bound) else $error("low count past ceiling");

	property p_state_legal;
		@(posedge ref_clk) disable iff (!rst_n)
		state == EIRL_IDLE || state == EIRL_ARMED || state == EIRL_LATCHED;
	endproperty
	a_state_legal: assert property (p_state_legal) else $error("illegal latch state");
endmodule

// file: bench/eirl_src.sv
// Source model: drives the request pin and the port lines.
// Assumes pull-ups, so released lines read high.
module eirl_src (
	// Clock
	input wire logic ref_clk,
	// Request lines
	output eirl_pkg::eirl_req_t req
);
	timeunit 1ns;
	timeprecision 100ps;
	import eirl_pkg::*;
	initial req = '{irq_n: 1'b1, port_a_lines: '1, port_a_enable: '1};
	task automatic hold(input logic level);
		req.irq_n = level;
	endtask
	task automatic set_enable(input logic [PORT_A_W-1:0] en);
		req.port_a_enable = en;
	endtask
	// Line 6 is the request pin, others are port lines
	task automatic pulse(input int id, input int n);
		@(posedge ref_clk);
		#1;
		if (id == 6) req.irq_n = 1'b0;
		else req.port_a_lines[id] = 1'b0;
		repeat (n) @(posedge ref_clk);
		#1;
		req.irq_n = 1'b1;
		req.port_a_lines = '1;
		repeat (SPACING_EXTRA_CYCLES) @(posedge ref_clk);
		#1;
	endtask
endmodule

// file: bench/tb.sv
// Testbench for the request latch.
// Checks both the level build and the edge-only build, driven by the source model.
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import eirl_pkg::*;
	logic ref_clk = 0, rst_n = 0, request_pending, start_sequence, edge_pending, edge_start;
	eirl_req_t req;
	eirl_cpu_t cpu = '0;
	int num_errors = 0, total_checks = 0, cycles = 0;
	eirl_src src (.ref_clk(ref_clk), .req(req));
	eirl_latch #(.LEVEL_SENSE(1'b1)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .cpu(cpu),
		.request_pending(request_pending), .start_sequence(start_sequence));
	eirl_latch #(.LEVEL_SENSE(1'b0)) dut_edge (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .cpu(cpu),
		.request_pending(edge_pending), .start_sequence(edge_start));
	initial forever #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			final_report();
		end
	end
	task automatic check(input logic seen, input logic exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %b want %b", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		if (num_errors == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// One instruction end with the given mask
	task automatic service(input logic mask, input logic exp);
		cpu = '{instr_done: 1'b1, mask_flag: mask};
		step(1);
		check(start_sequence, exp);
		check(request_pending, !exp);
		cpu.instr_done = 1'b0;
		step(1);
		check(start_sequence, 1'b0);
	endtask
	task automatic t_masked;
		src.pulse(6, 49);
		check(request_pending, 1'b0);
		src.pulse(6, 50);
		check(request_pending, 1'b1);
		step(3);
		check(start_sequence, 1'b0);
		service(1'b1, 1'b0);
		step(5);
		check(request_pending, 1'b1);
		service(1'b0, 1'b1);
	endtask
	task automatic t_port;
		src.pulse(3, 50);
		check(request_pending, 1'b1);
		service(1'b0, 1'b1);
		src.set_enable(6'h3d);
		src.pulse(1, 60);
		check(request_pending, 1'b0);
	endtask
	task automatic t_level;
		src.hold(1'b0);
		step(52);
		service(1'b0, 1'b1);
		step(2);
		check(request_pending, 1'b1);
		src.hold(1'b1);
		service(1'b0, 1'b1);
	endtask
	task automatic t_edge;
		src.hold(1'b0);
		step(52);
		check(edge_pending, 1'b1);
		service(1'b0, 1'b1);
		step(3);
		check(request_pending, 1'b1);
		check(edge_pending, 1'b0);
		src.hold(1'b1);
		service(1'b0, 1'b1);
		src.pulse(6, 50);
		check(edge_pending, 1'b1);
		check(request_pending, 1'b1);
		service(1'b0, 1'b1);
		check(edge_pending, 1'b0);
	endtask
	initial begin
		step(5);
		rst_n = 1'b1;
		t_masked();
		t_port();
		t_level();
		t_edge();
		final_report();
	end
endmodule
